// ===== bstap_pkg.sv
// Package for the boundary-scan test access port: states, instruction codes,
// register lengths and the pin bundle carried between processes.
// Assumes every user of it imports the whole package.
`default_nettype none
package bstap_pkg;

  // ==========================================================================
  // Register lengths
  localparam int IR_LEN  = 3;
  localparam int BSR_LEN = 71;
  localparam int ID_LEN  = 32;

  // ==========================================================================
  // Instruction codes (all zeros is the external-test code)
  localparam logic [IR_LEN-1:0] INS_EXTEST   = 3'h0;
  localparam logic [IR_LEN-1:0] INS_IDCODE   = 3'h1;
  localparam logic [IR_LEN-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_LEN-1:0] INS_SAMPLE   = 3'h4;
  localparam logic [IR_LEN-1:0] INS_BYPASS   = 3'h7;

  // Pattern loaded into all three instruction shift bits on capture
  localparam logic [IR_LEN-1:0] IR_CAPTURE   = 3'h1;

  // Identification value: arbitrary, bit 0 set as the scan convention asks
  localparam logic [ID_LEN-1:0] ID_VALUE     = 32'h1234_5001;

  // ==========================================================================
  // Controller states
  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_IDLE       = 4'h1,
    ST_SEL_DR     = 4'h2,
    ST_CAP_DR     = 4'h3,
    ST_SHIFT_DR   = 4'h4,
    ST_EXIT1_DR   = 4'h5,
    ST_PAUSE_DR   = 4'h6,
    ST_EXIT2_DR   = 4'h7,
    ST_UPD_DR     = 4'h8,
    ST_SEL_IR     = 4'h9,
    ST_CAP_IR     = 4'ha,
    ST_SHIFT_IR   = 4'hb,
    ST_EXIT1_IR   = 4'hc,
    ST_PAUSE_IR   = 4'hd,
    ST_EXIT2_IR   = 4'he,
    ST_UPD_IR     = 4'hf
  } bstap_state_e;

  // Test pins sampled together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bstap_pins_s;

endpackage : bstap_pkg
`default_nettype wire

// ===== bstap_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock shared by filler and drainer; in_ready is registered.
`timescale 1ns/1ps
`default_nettype none
module bstap_buf #(
  parameter int WIDTH = 71,            // Word width
  parameter int DEPTH = 2              // Entries, fixed at two
) (
  input  wire logic             clk,       // System clock
  input  wire logic             resetn,    // Async reset, active low
  input  wire logic             in_valid,  // Filler offers a word
  output var  logic             in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data,   // Word offered
  output logic                  out_valid, // A word is held
  input  wire logic             out_ready, // Drainer takes the word
  output logic      [WIDTH-1:0] out_data   // Oldest word
);

  // ==========================================================================
  // Elaboration check
  if (DEPTH != 2) begin : g_bad_depth
    $error("bstap_buf supports only two entries");
  end

  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;

  // Handshake decode
  wire logic       push       = in_valid & in_ready;
  wire logic       pop        = out_valid & out_ready;
  wire logic [1:0] next_count = count + {1'b0, push} - {1'b0, pop};

  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];

  // Storage; read data comes from the held entry
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers, count and registered ready so a full buffer stalls the filler
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
      count    <= 2'h0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr   <= wr_ptr ^ push;
      rd_ptr   <= rd_ptr ^ pop;
      count    <= next_count;
      in_ready <= (next_count != 2'h2);
    end
  end

endmodule : bstap_buf
`default_nettype wire

// ===== bstap_core.sv
// Boundary-scan test access port core: controller, instruction, bypass,
// identification and boundary registers, all stepped by edges of the test
// clock found by sampling it with the system clock.
// Assumes clk is at least eight times the test clock rate; pad pull-ups on
// the mode select and data input sit outside this logic.
`timescale 1ns/1ps
`default_nettype none
module bstap_core
  import bstap_pkg::*;
#(
  parameter int BLEN = BSR_LEN          // Boundary register length
) (
  input  wire logic            clk,        // System clock, 100 MHz
  input  wire logic            resetn,     // Async power-up reset, active low
  input  wire logic            tck,        // Test clock pin
  input  wire logic            tms,        // Mode select pin
  input  wire logic            tdi,        // Serial data input pin
  output var  logic            tdo,        // Serial data output
  output var  logic            tdo_oe,     // Serial output driven when high
  input  wire logic            snap_valid, // Pin snapshot offered
  output var  logic            snap_ready, // Snapshot buffer has room
  input  wire logic [BLEN-1:0] snap_data,  // Pin snapshot
  output var  logic            pins_hiz,   // Memory outputs to high impedance
  output var  logic [2:0]      instr       // Active instruction
);

  // ==========================================================================
  // Elaboration check
  if (BLEN < ID_LEN) begin : g_bad_len
    $error("boundary register shorter than identification register");
  end

  // ==========================================================================
  // Pin synchronisers and edge detection
  bstap_pins_s pin_meta;
  bstap_pins_s pin_sync;
  logic        tck_last;

  // Two flops before any logic reads a pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      pin_sync <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      tck_last <= 1'b0;
    end else begin
      pin_meta <= '{tck: tck, tms: tms, tdi: tdi};
      pin_sync <= pin_meta;
      tck_last <= pin_sync.tck;
    end
  end

  // A held-low test clock gives no edge, so the port stays put
  wire logic tck_rise = pin_sync.tck & ~tck_last;
  wire logic tck_fall = ~pin_sync.tck & tck_last;

  // ==========================================================================
  // Controller
  bstap_state_e state;
  bstap_state_e next_state;
  wire logic    m = pin_sync.tms;

  // Standard next-state table
  always_comb begin
    case (state)
      ST_RESET:    next_state = m ? ST_RESET    : ST_IDLE;
      ST_IDLE:     next_state = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   next_state = m ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = m ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = m ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   next_state = m ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = m ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = m ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
      default:     next_state = ST_RESET;
    endcase
  end

  // Power-up lands in reset; memory side sees only pins_hiz low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Register selection
  wire logic sel_ir  = (state == ST_CAP_IR) || (state == ST_SHIFT_IR);
  wire logic sel_id  = (instr == INS_IDCODE);
  wire logic sel_bsr = (instr == INS_EXTEST) || (instr == INS_SAMPLE) ||
                       (instr == INS_SAMPLE_Z);
  // Reserved codes fall to the bypass path as the shortest chain
  wire logic sel_byp = ~sel_id & ~sel_bsr;
  wire logic shifting = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);

  // ==========================================================================
  // Snapshot buffer feeding the boundary register
  logic            snap_take;
  logic            snap_have;
  logic [BLEN-1:0] snap_word;
  logic [BLEN-1:0] snap_hold;

  assign snap_take = tck_rise && (state == ST_CAP_DR) && sel_bsr;

  bstap_buf #(
    .WIDTH (BLEN),
    .DEPTH (2)
  ) u_snap (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (snap_valid),
    .in_ready  (snap_ready),
    .in_data   (snap_data),
    .out_valid (snap_have),
    .out_ready (snap_take),
    .out_data  (snap_word)
  );

  // Without a fresh word the capture repeats the last snapshot seen
  wire logic [BLEN-1:0] cap_pins = snap_have ? snap_word : snap_hold;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      snap_hold <= '0;
    end else if (snap_take) begin
      snap_hold <= cap_pins;
    end
  end

  // ==========================================================================
  // Instruction register
  logic [IR_LEN-1:0] ir_sh;

  // Capture, shift at MSB, update; reset reloads the identification code
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ir_sh <= '0;
      instr <= INS_IDCODE;
    end else if (tck_rise) begin
      case (state)
        ST_RESET:    instr <= INS_IDCODE;
        ST_CAP_IR:   ir_sh <= IR_CAPTURE;
        ST_SHIFT_IR: ir_sh <= {pin_sync.tdi, ir_sh[IR_LEN-1:1]};
        ST_UPD_IR:   instr <= ir_sh;
        default:     ir_sh <= ir_sh;
      endcase
    end
  end

  // External test and sample-z float the memory outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins_hiz <= 1'b0;
    end else begin
      pins_hiz <= (instr == INS_EXTEST) || (instr == INS_SAMPLE_Z);
    end
  end

  // ==========================================================================
  // Data registers: boundary shares its low bits with the ID path
  logic [BLEN-1:0] dr_sh;
  logic            byp;

  // Capture per instruction, then shift toward the LSB from the MSB end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dr_sh <= '0;
      byp   <= 1'b0;
    end else if (tck_rise && (state == ST_CAP_DR)) begin
      if (sel_bsr) begin
        dr_sh <= cap_pins;
      end else if (sel_id) begin
        dr_sh[ID_LEN-1:0] <= ID_VALUE;
      end else begin
        byp <= 1'b0;
      end
    end else if (tck_rise && (state == ST_SHIFT_DR)) begin
      if (sel_bsr) begin
        dr_sh <= {pin_sync.tdi, dr_sh[BLEN-1:1]};
      end else if (sel_id) begin
        dr_sh[ID_LEN-1:0] <= {pin_sync.tdi, dr_sh[ID_LEN-1:1]};
      end else begin
        byp <= pin_sync.tdi;
      end
    end
  end

  // ==========================================================================
  // Serial output
  wire logic out_bit = sel_ir ? ir_sh[0] : (sel_byp ? byp : dr_sh[0]);

  // Launched on the fall so the tester samples a settled bit on the rise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= out_bit;
      tdo_oe <= shifting;
    end
  end

endmodule : bstap_core
`default_nettype wire

// ===== bstap_tester.sv
// Tester model for the far side of the test port link.
// Assumes step() is called at a falling edge of the system clock.
`timescale 1ns/1ps
`default_nettype none
module bstap_tester (
  input  wire logic clk,   // System clock, pacing only
  output var  logic tck,   // Test clock, 80 ns period
  output var  logic tms,   // Mode select
  output var  logic tdi,   // Serial data in
  input  wire logic tdo,   // Resolved serial out wire
  output var  logic seen,  // Pulses when a taken bit is to be checked
  output var  logic bit_v  // Bit taken from tdo
);
  // ==========================================================================
  // Idle levels: clock parked low, data pins at their pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    seen = 1'b0;
    bit_v = 1'b0;
  end

  // One test clock period; tdo is taken late in the low phase, well after
  // the fall that launched it, so the port's sync delay never races it
  task automatic step(input logic m, input logic dv, input logic chk);
    tms = m;
    tdi = dv;
    repeat (4) @(negedge clk);
    bit_v = tdo;
    seen = chk;
    tck = 1'b1;
    repeat (4) @(negedge clk);
    seen = 1'b0;
    tck = 1'b0;
  endtask : step
endmodule : bstap_tester
`default_nettype wire

// ===== bstap_core_properties.sv
// Checks on the test port pins and the snapshot handshake.
// Assumes test clock phases of at least four system clocks.
`timescale 1ns/1ps
`default_nettype none
module bstap_core_properties
  import bstap_pkg::*;
(
  input wire logic       clk,        // System clock
  input wire logic       resetn,     // Async reset, active low
  input wire logic       tck,        // Test clock pin
  input wire logic       tms,        // Mode select pin
  input wire logic       tdo,        // Serial out
  input wire logic       tdo_oe,     // Serial out enable
  input wire logic       snap_valid, // Snapshot offered
  input wire logic       snap_ready, // Snapshot room
  input wire logic       pins_hiz,   // Memory outputs off
  input wire logic [2:0] instr       // Active instruction
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ==========================================================================
  // Cycles since the last pin fall and rise, and the run of rises with tms high
  logic       tck_d;
  logic [3:0] fall_age;
  logic [3:0] rise_age;
  logic [3:0] ones;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tck_d <= 1'b0;
      fall_age <= 4'hf;
      rise_age <= 4'hf;
      ones <= 4'h0;
    end else begin
      tck_d <= tck;
      fall_age <= (tck_d && !tck) ? 4'h1 : fall_age + 4'(fall_age != 4'hf);
      rise_age <= (!tck_d && tck) ? 4'h1 : rise_age + 4'(rise_age != 4'hf);
      if (!tck_d && tck) ones <= tms ? ones + 4'(ones != 4'hf) : 4'h0;
    end
  end

  // ==========================================================================
  // Output timing against test clock edges, reset values, float decode and buffer fill
  a_tdo_on_fall: assert property ($changed(tdo) |-> fall_age inside {[1:6]})
    else $error("serial out moved away from a clock fall");
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> fall_age inside {[1:6]})
    else $error("driver enable moved away from a clock fall");
  a_quiet_hold: assert property (fall_age == 4'hf && !tck |-> $stable(tdo) && $stable(tdo_oe))
    else $error("serial out moved with the test clock parked");
  a_instr_on_rise: assert property ($changed(instr) |-> rise_age inside {[1:8]})
    else $error("instruction moved away from a clock rise");
  a_tap_reset: assert property (!tck_d && tck && tms && ones >= 4'h5
    |-> ##[1:12] (instr == INS_IDCODE && !tdo_oe))
    else $error("five mode-high rises did not reset the port");
  a_reset_vals: assert property ($rose(resetn)
    |-> snap_ready && !tdo_oe && !pins_hiz && instr == INS_IDCODE)
    else $error("port left reset with wrong outputs");
  a_hiz_decode: assert property (instr == $past(instr)
    |-> pins_hiz == (instr == INS_EXTEST || instr == INS_SAMPLE_Z))
    else $error("output float does not follow the instruction");
  a_snap_full: assert property (snap_valid && snap_ready ##1 snap_valid && snap_ready
    |-> ##[1:2] !snap_ready)
    else $error("snapshot buffer took a third word");

  c_shift_out: cover property ($rose(tdo_oe));
  c_tap_reset: cover property (!tck_d && tck && tms && ones >= 4'h5);
  c_buf_full: cover property (snap_valid && !snap_ready);
endmodule : bstap_core_properties

bind bstap_core bstap_core_properties bstap_core_properties_i (.clk(clk), .resetn(resetn),
  .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe), .snap_valid(snap_valid),
  .snap_ready(snap_ready), .pins_hiz(pins_hiz), .instr(instr));
`default_nettype wire

// ===== testbench.sv
// Bench for the test port core: tester model on the link, random words on
// the snapshot stream, serial output scored against a queue of notes.
// Assumes the package, tester model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import bstap_pkg::*;
;
  logic        clk, resetn, tck, tms, tdi, tdo, tdo_oe, seen, bit_v;
  logic        snap_valid, snap_ready, pins_hiz;
  logic [70:0] snap_data, a, b, c, d;
  logic [2:0]  instr;
  wire logic   tdo_w;
  logic        q[$];
  int          mismatches, total_checks;
  int          seed = 32'h8da1971a;

  // ==========================================================================
  // Pin float is visible to the tester, so a bit taken off-shift mismatches
  assign tdo_w = tdo_oe ? tdo : 1'bz;
  bstap_core #(.BLEN(71)) bstap_core_i (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .snap_valid(snap_valid), .snap_ready(snap_ready),
    .snap_data(snap_data), .pins_hiz(pins_hiz), .instr(instr));
  bstap_tester bstap_tester_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w),
    .seen(seen), .bit_v(bit_v));

  task automatic check(input logic [70:0] s, input logic [70:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic finish_test();
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  function automatic logic [70:0] rnd();
    return 71'({$random(seed), $random(seed), $random(seed)});
  endfunction : rnd

  task automatic st(input logic m, input logic dv, input logic chk);
    bstap_tester_i.step(m, dv, chk);
  endtask : st

  // Idle to a shift state, n bits with expected output noted, back to idle
  task automatic scan(input logic ir, input int n, input logic [70:0] din,
                      input logic [70:0] ex);
    st(1'b1, 1'b1, 1'b0);
    if (ir) st(1'b1, 1'b1, 1'b0);
    repeat (2) st(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      q.push_back(ex[i]);
      st(i == n - 1, din[i], 1'b1);
    end
    st(1'b1, 1'b1, 1'b0);
    st(1'b0, 1'b1, 1'b0);
  endtask : scan

  // Offer a word and hold it until taken; valid stays up for back to back
  task automatic push(input logic [70:0] w);
    snap_data = w;
    snap_valid = 1'b1;
    for (int n = 0; n < 3000 && snap_ready !== 1'b1; n++) @(negedge clk);
    // A buffer that never frees a slot counts against the run
    check(71'(snap_ready), 71'(1));
    @(negedge clk);
  endtask : push

  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog, several times the expected run
  initial begin
    #200us;
    mismatches++;
    finish_test();
  end

  // Scoreboard: every bit the tester flags with seen meets the oldest note
  always @(posedge seen) check(71'(bit_v), 71'(q.pop_front()));

  initial begin
    resetn = 1'b0;
    snap_valid = 1'b0;
    snap_data = '0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check(71'({instr, tdo_oe, pins_hiz, snap_ready}), 71'({INS_IDCODE, 3'h1}));
    a = rnd();
    b = rnd();
    c = rnd();
    push(a);
    push(b);
    snap_valid = 1'b0;
    @(negedge clk);
    check(71'(snap_ready), 71'(0));
    st(1'b0, 1'b1, 1'b0);
    // Every code; boundary codes drain the buffer, then recapture the last
    for (int k = 0; k < 8; k++) begin
      d = rnd();
      scan(1'b1, 3, 71'(k), 71'(IR_CAPTURE));
      check(71'({instr, pins_hiz}), 71'({3'(k), k == 0 || k == 2}));
      if (k == 1) scan(1'b0, 32, d, 71'(ID_VALUE));
      else if (k == 3 || k > 4) scan(1'b0, 8, d, {d[69:0], 1'b0});
      else begin
        if (k == 0) begin
          fork
            push(c);
            scan(1'b0, 71, d, a);
          join
          snap_valid = 1'b0;
          scan(1'b0, 71, d, b);
        end
        scan(1'b0, 71, d, c);
      end
    end
    // Mode select held high from mid-shift brings back the reset state
    st(1'b1, 1'b1, 1'b0);
    repeat (2) st(1'b0, 1'b1, 1'b0);
    repeat (6) st(1'b1, 1'b1, 1'b0);
    repeat (6) @(negedge clk);
    check(71'({instr, tdo_oe}), 71'({INS_IDCODE, 1'b0}));
    finish_test();
  end
endmodule : testbench
`default_nettype wire
